// ### rtl/switching_clock_fault_reaction.sv
// Fault reaction and restart control for regulator switching-clock errors.
// Assumes all inputs synchronous to clock; MCU controls arrive as plain pins.
//
// Function
// R1: Boost clock fault: flag, boost off, safe, count, interrupt
// R2: Boost undervoltage with setting 1b enters reset
// R3: Boost restarts below restart level, clocks good
// R4: Self-test runs after rails up, no reset condition
// R5: Self-test fail returns safe; threshold reached goes off
// R6: Boost not ramping within reset timeout goes off
// R7: Setting 0b stays safe; MCU re-enables boost
// R8: MCU may test and disable clock monitors
// R9: Sync fault: flag, safe, PLL off, count, interrupt; code only clears pll_track, the VCO keeps running
// R10: PLL fault: flag, safe, all rails off, count
// R11: Configured undervoltage after clock fault enters reset
// R12: Stepdown one restarts only with clocks, rails discharged
// R13: Stepdown two and boost follow stepdown one good
// R14: Reset entry clears sync monitor, stops PLL tracking
// R15: Rails start only with PLL and rail monitors good
// R16: Sync monitor stays off until software sets it
// R17: MCU enables sync monitor after driving sync clock
// R18: PLL fault holds reset; timeout goes off, latched
// R19: Stepdown one clock fault disables all rails, safe
// R20: Four-bit power-down threshold forces off from safe
// R21: Fault flags stay set until software clears
// R22: Interrupt pin held low throughout safe after fault
`timescale 1ns/1ns
`default_nettype none
`include "clk_fault_defines.svh"

module switching_clock_fault_reaction
	import clk_fault_pkg::*;
#(
	parameter int RST_TO_CYC = `RST_TIMEOUT_US * `CLK_MHZ
)
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Clock monitors
	input  wire logic              osc_good,
	input  wire logic              ext_clk_cfg,
	input  wire logic              clk_mon_disable,
	input  wire logic              sync_clk_bad,
	input  wire logic              pll_clk_bad,
	input  wire logic              sd1_clk_bad,
	input  wire logic              boost_clk_bad,
	// Rail feedback
	input  wire logic              sd1_uv,
	input  wire logic              sd2_uv,
	input  wire logic              boost_uv,
	input  wire logic              sd1_below_60,
	input  wire logic              sd2_below_60,
	input  wire logic              boost_below_restart,
	// Configuration
	input  wire logic              sd1_uv_rst_en,
	input  wire logic              sd2_uv_rst_en,
	input  wire logic              boost_uv_as_reset_setting,
	input  wire logic [`CNT_W-1:0] power_down_threshold,
	// MCU controls
	input  wire logic              wake,
	input  wire logic              diag_exit,
	input  wire logic              boost_enable_bit,
	input  wire logic              sync_monitor_set,
	input  wire logic              sync_monitor_clr,
	input  wire logic [`FLT_N-1:0] flag_clr,
	// Analog self-test
	input  wire logic              self_test_done,
	input  wire logic              self_test_pass,
	output logic                   analog_self_test_start,
	// Rail enables
	output logic                   sd1_en,
	output logic                   sd2_en,
	output logic                   boost_en,
	output logic                   pll_track,
	// Status
	output logic                   sync_monitor_enable_bit,
	output logic                   boost_clock_fault_flag,
	output logic                   stepdown1_clock_fault_flag,
	output logic                   sync_clock_fault_flag,
	output logic                   switching_source_fault_flag,
	output logic [2:0]             dev_state,
	output logic [`CNT_W-1:0]      error_count,
	output logic                   reset_timeout_latch,
	// System pins
	output logic                   reset_output,
	output logic                   interrupt_pin_n
);
	// Last count of the reset-state timeout; the count restarts at zero on every entry
	localparam logic [`TO_W-1:0] TO_LAST = `TO_W'(RST_TO_CYC - 1);

	// Registered state and its next value; one struct holds every flop of the core
	core_type          q;
	core_type          n;
	// Qualified fault events and restart gates
	logic [`FLT_N-1:0] acc;
	logic              uv_rst;
	logic              sd1_gate;
	logic              boost_gate;
	logic              inc;
	logic              cnt_clr;

	fault_evt_if evt ();

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	clk_fault_detect u_det (
		.clock           (clock),
		.rst             (rst),
		.osc_good        (osc_good),
		.ext_clk_cfg     (ext_clk_cfg),
		.clk_mon_disable (clk_mon_disable),
		.sync_clk_bad    (sync_clk_bad),
		.pll_clk_bad     (pll_clk_bad),
		.sd1_clk_bad     (sd1_clk_bad),
		.boost_clk_bad   (boost_clk_bad),
		.evt             (evt.det)
	);

	err_count u_cnt (
		.clock (clock),
		.rst   (rst),
		.cif   (evt.ctr)
	);

	assign evt.mon_en = q.sync_mon_en;
	assign evt.inc    = inc;
	assign evt.clr    = cnt_clr;
	assign evt.th     = power_down_threshold; // [R20]

	// ------------------------------------------------------------
	// Entry helpers
	// ------------------------------------------------------------
	function automatic core_type enter_reset(input core_type c);
		core_type r;
		r = c;
		r.state       = ST_RESET;
		// The sync input is not driven while the controller reboots
		r.sync_mon_en = 1'b0; // [R14]
		r.pll_track   = 1'b0; // [R14]
		r.reset_out   = 1'b0;
		r.irq_hold    = 1'b0;
		r.st_busy     = 1'b0;
		r.to_cnt      = '0;
		enter_reset = r;
	endfunction

	function automatic core_type enter_off(input core_type c);
		core_type r;
		r = c;
		r.state       = ST_OFF;
		// Timeout latch and error count are kept so the cause stays readable
		r.sd1_en      = 1'b0;
		r.sd2_en      = 1'b0;
		r.boost_en    = 1'b0;
		r.pll_track   = 1'b0;
		r.sync_mon_en = 1'b0;
		r.reset_out   = 1'b0;
		r.irq_hold    = 1'b0;
		r.st_busy     = 1'b0;
		enter_off = r;
	endfunction

	// ------------------------------------------------------------
	// Gating terms
	// ------------------------------------------------------------
	always_comb begin
		// Faults are ignored while powered down
		acc = (q.state == ST_OFF) ? '0 : evt.ev;
		// Any configured undervoltage is a reset condition
		uv_rst = (sd1_uv & sd1_uv_rst_en) // [R11]
			| (sd2_uv & sd2_uv_rst_en) // [R11]
			| (boost_uv & boost_uv_as_reset_setting); // [R2]
		// Sync monitor is off in reset, so only PLL and rail monitors count
		sd1_gate = ~pll_clk_bad // [R15]
			& ~sd1_clk_bad // [R15]
			& ~(sync_clk_bad & q.sync_mon_en)
			// Both stepdowns discharged and boost below its restart level
			& sd1_below_60 // [R12]
			& sd2_below_60 // [R12]
			& boost_below_restart; // [R12]
		// Boost also waits for its own switching clock
		boost_gate = boost_below_restart // [R3]
			& ~pll_clk_bad
			& ~boost_clk_bad
			& ~(sync_clk_bad & q.sync_mon_en);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = q;
		n.st_start = 1'b0;
		inc = 1'b0;
		cnt_clr = 1'b0;
		// A set in the clearing cycle wins, so no fault is lost
		n.flags = sticky(q.flags, acc, flag_clr); // [R21]
		if (|acc) begin
			n.state    = ST_SAFE;
			n.irq_hold = 1'b1; // [R1] [R22]
			n.st_busy  = 1'b0;
			// Several faults in one cycle count as one error
			inc = 1'b1;
			if (acc[`FLT_BOOST]) begin
				n.boost_en = 1'b0; // [R1]
			end
			if (acc[`FLT_SYNC]) begin
				// Regulators keep switching from the free-running VCO
				n.pll_track = 1'b0; // [R9]
			end
			if (acc[`FLT_PLL] || acc[`FLT_SD1]) begin
				n.sd1_en   = 1'b0; // [R10] [R19]
				n.sd2_en   = 1'b0;
				n.boost_en = 1'b0;
			end
		end else begin
			unique case (q.state)
				ST_OFF: begin
					if (wake) begin
						// Entry helpers start from the next value so a same-cycle flag clear is kept
						n = enter_reset(n);
						n.to_latch = 1'b0;
						cnt_clr = 1'b1;
					end
				end
				ST_RESET: begin
					if (q.to_cnt == TO_LAST) begin
						// Covers a rail that never ramps and a PLL that never recovers
						n = enter_off(n); // [R6] [R18]
						n.to_latch = 1'b1; // [R18]
					end else begin
						n.to_cnt = q.to_cnt + `TO_W'(1);
						// Restart order: stepdown one, then stepdown two and boost, then self-test
						if (!q.sd1_en && sd1_gate) begin
							n.sd1_en = 1'b1; // [R12]
						end
						if (q.sd1_en && !sd1_uv) begin
							n.sd2_en = 1'b1; // [R13]
							if (!q.boost_en && boost_gate) begin
								n.boost_en = 1'b1; // [R3] [R13]
							end
						end
						if (q.sd1_en && q.sd2_en && q.boost_en && !uv_rst
							&& !pll_clk_bad && !q.st_busy) begin
							n.st_start = 1'b1; // [R4] [R18]
							n.st_busy  = 1'b1;
						end
						if (q.st_busy && self_test_done) begin
							n.st_busy = 1'b0;
							if (self_test_pass) begin
								// Reset output extension ends with a passing self-test
								n.state     = ST_DIAG;
								n.reset_out = 1'b1;
							end else begin
								n.state    = ST_SAFE; // [R5]
								n.irq_hold = 1'b1;
								inc = 1'b1;
							end
						end
					end
				end
				ST_DIAG: begin
					// Monitor enable is taken only once reset is released
					if (uv_rst) begin
						n = enter_reset(n); // [R2]
					end else begin
						if (diag_exit) begin
							n.state = ST_ACTIVE;
						end
						if (sync_monitor_set) begin
							n.sync_mon_en = 1'b1; // [R16]
							n.pll_track   = 1'b1;
						end else if (sync_monitor_clr) begin
							n.sync_mon_en = 1'b0;
						end
					end
				end
				ST_ACTIVE: begin
					if (uv_rst) begin
						n = enter_reset(n); // [R2]
					end else if (sync_monitor_set) begin
						n.sync_mon_en = 1'b1; // [R16]
						n.pll_track   = 1'b1;
					end else if (sync_monitor_clr) begin
						n.sync_mon_en = 1'b0;
					end
				end
				ST_SAFE: begin
					// Threshold is checked first so the retry loop cannot run forever
					if (evt.at_th) begin
						n = enter_off(n); // [R5] [R20]
					end else if (uv_rst) begin
						n = enter_reset(n); // [R11] [R2]
					end else begin
						if (boost_enable_bit && !boost_uv_as_reset_setting) begin
							n.boost_en = 1'b1; // [R7]
						end
						if (sync_monitor_set) begin
							n.sync_mon_en = 1'b1; // [R16]
							n.pll_track   = 1'b1;
						end else if (sync_monitor_clr) begin
							n.sync_mon_en = 1'b0;
						end
					end
				end
				default: begin
					n = enter_off(n);
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Everything clears to OFF with all rails disabled and the interrupt released
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign analog_self_test_start      = q.st_start;
	assign sd1_en                      = q.sd1_en;
	assign sd2_en                      = q.sd2_en;
	assign boost_en                    = q.boost_en;
	assign pll_track                   = q.pll_track;
	assign sync_monitor_enable_bit     = q.sync_mon_en;
	assign boost_clock_fault_flag      = q.flags[`FLT_BOOST];
	assign stepdown1_clock_fault_flag  = q.flags[`FLT_SD1];
	assign sync_clock_fault_flag       = q.flags[`FLT_SYNC];
	assign switching_source_fault_flag = q.flags[`FLT_PLL];
	assign dev_state                   = q.state;
	assign error_count                 = evt.cnt;
	assign reset_timeout_latch         = q.to_latch;
	assign reset_output                = q.reset_out;
	// Active low, held for the whole stay in safe
	assign interrupt_pin_n             = ~q.irq_hold;
endmodule

`default_nettype wire

// ### rtl/clk_fault_defines.svh
// Constants for the switching-clock fault reaction block.
// Included by the package and by every design file; definitions only.
`ifndef CLK_FAULT_DEFINES_SVH
`define CLK_FAULT_DEFINES_SVH

// Fault event bit positions
`define FLT_BOOST 0
`define FLT_SD1 1
`define FLT_SYNC 2
`define FLT_PLL 3
`define FLT_N 4

// Widths and counter saturation value
`define CNT_W 4
`define CNT_MAX 4'hF
`define TO_W 24

// Timing
`define CLK_MHZ 10
`define RST_TIMEOUT_US 10000

`endif

// ### rtl/clk_fault_pkg.sv
// Types shared by the switching-clock fault reaction design files.
// Assumes clk_fault_defines.svh is on the include path.
`include "clk_fault_defines.svh"

package clk_fault_pkg;

	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_RESET  = 3'b001,
		ST_DIAG   = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_SAFE   = 3'b100
	} dev_state_type;

	typedef struct packed {
		dev_state_type          state;
		logic [`FLT_N-1:0]      flags;
		logic                   sd1_en;
		logic                   sd2_en;
		logic                   boost_en;
		logic                   pll_track;
		logic                   sync_mon_en;
		logic                   reset_out;
		logic                   irq_hold;
		logic                   st_busy;
		logic                   st_start;
		logic                   to_latch;
		logic [`TO_W-1:0]       to_cnt;
	} core_type;

	typedef struct packed {
		logic [`FLT_N-1:0] prev;
	} det_type;

	typedef struct packed {
		logic [`CNT_W-1:0] cnt;
	} cnt_type;

	// Sticky flag update: a set in the clearing cycle wins
	function automatic logic [`FLT_N-1:0] sticky(input logic [`FLT_N-1:0] q,
		input logic [`FLT_N-1:0] set, input logic [`FLT_N-1:0] clr);
		sticky = (q & ~clr) | set;
	endfunction

endpackage

// ### rtl/fault_evt_if.sv
// Carrier between the fault detector, the error counter and the core.
// Assumes one clock domain; all signals are synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "clk_fault_defines.svh"

interface fault_evt_if;
	logic [`FLT_N-1:0]  ev;
	logic               mon_en;
	logic               inc;
	logic               clr;
	logic [`CNT_W-1:0]  th;
	logic [`CNT_W-1:0]  cnt;
	logic               at_th;

	modport det  (output ev, input mon_en);
	modport ctr  (input inc, input clr, input th, output cnt, output at_th);
	modport core (input ev, output mon_en, output inc, output clr, output th, input cnt, input at_th);
endinterface

`default_nettype wire

// ### rtl/clk_fault_detect.sv
// Qualifies raw clock-monitor fault levels and emits one-cycle events.
// Assumes raw monitor levels are synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
`include "clk_fault_defines.svh"

module clk_fault_detect
	import clk_fault_pkg::*;
(
	// Clock and reset
	input  wire logic     clock,
	input  wire logic     rst,
	// Monitor levels
	input  wire logic     osc_good,
	input  wire logic     ext_clk_cfg,
	input  wire logic     clk_mon_disable,
	input  wire logic     sync_clk_bad,
	input  wire logic     pll_clk_bad,
	input  wire logic     sd1_clk_bad,
	input  wire logic     boost_clk_bad,
	// Events out
	fault_evt_if.det      evt
);
	det_type           q;
	det_type           n;
	logic [`FLT_N-1:0] qual;

	always_comb begin
		// Faults only count while the internal oscillator is trusted
		qual = '0;
		qual[`FLT_BOOST] = boost_clk_bad;
		qual[`FLT_SD1]   = sd1_clk_bad & ext_clk_cfg;
		qual[`FLT_SYNC]  = sync_clk_bad & ext_clk_cfg & evt.mon_en;
		qual[`FLT_PLL]   = pll_clk_bad & ext_clk_cfg;
		qual = qual & {`FLT_N{osc_good & ~clk_mon_disable}};
		n.prev = qual;
	end

	assign evt.ev = qual & ~q.prev;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

`default_nettype wire

// ### rtl/err_count.sv
// Device error counter with power-down threshold compare.
// Assumes increments arrive as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "clk_fault_defines.svh"

module err_count
	import clk_fault_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Counter port
	fault_evt_if.ctr  cif
);
	cnt_type q;
	cnt_type n;

	always_comb begin
		n = q;
		if (cif.clr) begin
			n.cnt = '0;
		end else if (cif.inc && q.cnt != `CNT_MAX) begin
			// Saturates so a burst of faults cannot wrap below the threshold
			n.cnt = q.cnt + `CNT_W'(1);
		end
	end

	assign cif.cnt   = q.cnt;
	assign cif.at_th = (q.cnt >= cif.th);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
endmodule

`default_nettype wire

// ### test/clk_fault_checker.sv
// Port-level assertions for the switching-clock fault reaction block.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "clk_fault_defines.svh"

module clk_fault_checker #(
	parameter int RST_TO_CYC = 50
) (
	input wire logic                clock, rst, osc_good, ext_clk_cfg, clk_mon_disable,
	input wire logic                sync_clk_bad, pll_clk_bad, sd1_clk_bad, boost_clk_bad,
	input wire logic                sd1_uv, sd1_below_60, sd2_below_60, boost_below_restart,
	input wire logic                analog_self_test_start, sd1_en, sd2_en, boost_en, pll_track,
	input wire logic                sync_monitor_enable_bit, boost_clock_fault_flag,
	input wire logic                stepdown1_clock_fault_flag, sync_clock_fault_flag,
	input wire logic                switching_source_fault_flag, reset_timeout_latch, interrupt_pin_n,
	input wire logic [`FLT_N-1:0]   flag_clr,
	input wire logic [2:0]          dev_state,
	input wire logic [`CNT_W-1:0]   error_count, power_down_threshold
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire q = osc_good && !clk_mon_disable && dev_state != 3'h0;
	wire x = q && ext_clk_cfg;
	wire [3:0] f = {switching_source_fault_flag, sync_clock_fault_flag,
		stepdown1_clock_fault_flag, boost_clock_fault_flag};
	logic [31:0] rcnt_r;
	// Cycles spent in reset; bounds the restart wait
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rcnt_r <= '0;
		else if (dev_state == 3'h1)
			rcnt_r <= rcnt_r + 32'd1;
		else
			rcnt_r <= '0;
	end
	sequence boost_ev_s; $rose(boost_clk_bad) && q; endsequence
	sequence st_start_s; $rose(analog_self_test_start); endsequence
	boost_fault_a: assert property (boost_ev_s |=> boost_clock_fault_flag && !boost_en && dev_state == 3'h4)
		else $error("boost fault reaction wrong");
	count_step_a: assert property (boost_ev_s ##0 error_count != 4'hF |-> ##2 error_count == $past(error_count, 2) + 4'h1)
		else $error("error count did not step");
	sync_fault_a: assert property ($rose(sync_clk_bad) && x && sync_monitor_enable_bit |=> sync_clock_fault_flag && !pll_track && dev_state == 3'h4)
		else $error("sync fault reaction wrong");
	pll_fault_a: assert property ($rose(pll_clk_bad) && x |=> switching_source_fault_flag && !sd1_en && !sd2_en && !boost_en)
		else $error("pll fault reaction wrong");
	sd1_fault_a: assert property ($rose(sd1_clk_bad) && x |=> stepdown1_clock_fault_flag && !sd1_en && !sd2_en && !boost_en)
		else $error("stepdown one fault reaction wrong");
	sd1_gate_a: assert property ($rose(sd1_en) |-> $past(dev_state) == 3'h1 && $past(!pll_clk_bad && sd1_below_60 && sd2_below_60 && boost_below_restart))
		else $error("stepdown one started while gated");
	rail_order_a: assert property ($rose(sd2_en) |-> sd1_en && $past(!sd1_uv))
		else $error("stepdown two before stepdown one good");
	boost_gate_a: assert property ($rose(boost_en) && $past(dev_state) == 3'h1 |-> $past(boost_below_restart && !boost_clk_bad && !pll_clk_bad))
		else $error("boost restarted while gated");
	test_start_a: assert property (st_start_s |-> sd1_en && sd2_en && boost_en && dev_state == 3'h1)
		else $error("self-test started early");
	reset_entry_a: assert property (dev_state == 3'h1 |-> !sync_monitor_enable_bit && !pll_track)
		else $error("sync monitor or tracking live in reset");
	timeout_off_a: assert property ($rose(reset_timeout_latch) |-> dev_state == 3'h0 && !sd1_en && !sd2_en && !boost_en)
		else $error("timeout did not power down");
	reset_bound_a: assert property (rcnt_r <= RST_TO_CYC + 2)
		else $error("reset outlived its timeout");
	power_down_a: assert property (dev_state == 3'h4 && error_count >= power_down_threshold |=> dev_state == 3'h0)
		else $error("threshold reached without power down");
	flags_hold_a: assert property ((f & ~flag_clr) != 4'h0 |=> (f & $past(f & ~flag_clr)) == $past(f & ~flag_clr))
		else $error("fault flag dropped uncleared");
	irq_safe_a: assert property (!interrupt_pin_n |-> dev_state == 3'h4)
		else $error("interrupt low outside safe");
endmodule

`default_nettype wire

// ### test/rail_mcu_model.sv
// Stand-in for the rails, the self-test engine and the microcontroller.
// Assumes rail enables and the self-test start pulse are registered.
`timescale 1ns/1ns
`default_nettype none

module rail_mcu_model (
	input  wire logic clock, rst, sd1_en, sd2_en, boost_en,
	input  wire logic reset_output, analog_self_test_start, st_fail,
	output logic      sd1_uv, sd1_below_60, sd2_below_60, boost_below_restart,
	output logic      self_test_done, self_test_pass, sync_monitor_set
);
	logic [1:0] ramp_r;
	logic [2:0] st_r;
	logic       rel_r;
	// Stepdown one rises and discharges two cycles after its enable changes; stepdown two and boost are discharged once switched off
	assign sd1_uv = !ramp_r[1];
	assign sd1_below_60 = !sd1_en && !ramp_r[1];
	assign sd2_below_60 = !sd2_en;
	assign boost_below_restart = !boost_en;
	assign self_test_done = st_r[2];
	assign self_test_pass = st_r[2] && !st_fail;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ramp_r <= '0;
			st_r <= '0;
			rel_r <= 1'b0;
			sync_monitor_set <= 1'b0;
		end else begin
			ramp_r <= {ramp_r[0], sd1_en};
			st_r <= {st_r[1:0], analog_self_test_start};
			rel_r <= reset_output;
			sync_monitor_set <= reset_output && !rel_r;
		end
	end
endmodule

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the switching-clock fault reaction block.
// Assumes the rail and microcontroller model sits on the far side.
`timescale 1ns/1ns
`default_nettype none

module tb;
	localparam int RST_TO_CYC = 50;
	typedef struct packed {
		logic [3:0] bad;
		logic [2:0] rails;
	} row_type;
	logic       clock = 0, rst = 1, osc_good = 1, ext_clk_cfg = 1, clk_mon_disable = 0;
	logic       sync_clk_bad = 0, pll_clk_bad = 0, sd1_clk_bad = 0, boost_clk_bad = 0;
	logic       sd2_uv = 0, boost_uv = 0, sd1_uv_rst_en = 0, sd2_uv_rst_en = 0;
	logic       boost_uv_as_reset_setting = 0, wake = 0, diag_exit = 0, boost_enable_bit = 0;
	logic       sync_monitor_clr = 0, st_fail = 0;
	logic [3:0] flag_clr = 4'h0, power_down_threshold = 4'hF, error_count;
	logic       sd1_uv, sd1_below_60, sd2_below_60, boost_below_restart, self_test_done;
	logic       self_test_pass, sync_monitor_set, analog_self_test_start, sd1_en, sd2_en;
	logic       boost_en, pll_track, sync_monitor_enable_bit, boost_clock_fault_flag;
	logic       stepdown1_clock_fault_flag, sync_clock_fault_flag, switching_source_fault_flag;
	logic       reset_timeout_latch, reset_output, interrupt_pin_n;
	logic [2:0] dev_state;
	wire  [3:0] flags = {switching_source_fault_flag, sync_clock_fault_flag,
		stepdown1_clock_fault_flag, boost_clock_fault_flag};
	int         fails = 0, tests_run = 0;
	// Fault bits {pll, sync, sd1, boost}; rails {sd1, sd2, boost} left on
	row_type    rows [4] = '{'{4'h1, 3'b110}, '{4'h2, 3'b000}, '{4'h4, 3'b111}, '{4'h8, 3'b000}};

	switching_clock_fault_reaction #(.RST_TO_CYC(RST_TO_CYC)) u_switching_clock_fault_reaction (.*);
	rail_mcu_model u_rail_mcu_model (.*);

	always #50 clock = ~clock;

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Every wait is bounded; running out ends the run
	task automatic wait_st(input logic [2:0] s);
		int n;
		n = 0;
		while (dev_state !== s && n < 200) begin
			cyc(1);
			n++;
		end
		if (dev_state !== s) begin
			fails++;
			$display("[FAIL] %0t state wait ran out", $time);
			close_out();
		end
	endtask

	task automatic boot;
		rst = 1;
		cyc(3);
		rst = 0;
		wake = 1;
		wait_st(3'h1);
		wake = 0;
	endtask

	task automatic up;
		boot();
		wait_st(3'h2);
		diag_exit = 1;
		cyc(1);
		diag_exit = 0;
		wait_st(3'h3);
		cyc(1);
		chk({7'h00, sync_monitor_enable_bit}, 8'h01);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		foreach (rows[i]) begin
			up();
			{pll_clk_bad, sync_clk_bad, sd1_clk_bad, boost_clk_bad} = rows[i].bad;
			cyc(1);
			chk({1'b0, dev_state, flags}, {4'h4, rows[i].bad});
			chk({4'h0, interrupt_pin_n, sd1_en, sd2_en, boost_en}, {5'h00, rows[i].rails});
			if (rows[i].bad[2])
				chk({7'h00, pll_track}, 8'h00);
			cyc(1);
			chk({4'h0, error_count}, 8'h01);
			{pll_clk_bad, sync_clk_bad, sd1_clk_bad, boost_clk_bad} = 4'h0;
			cyc(2);
			chk({3'h0, interrupt_pin_n, flags}, {4'h0, rows[i].bad});
			flag_clr = 4'hF;
			cyc(1);
			flag_clr = 4'h0;
			chk({4'h0, flags}, 8'h00);
			$display("test fault row %0d done", i);
		end
		up();
		clk_mon_disable = 1;
		boost_clk_bad = 1;
		cyc(2);
		chk({5'h00, dev_state}, 8'h03);
		boost_clk_bad = 0;
		clk_mon_disable = 0;
		cyc(1);
		boost_clk_bad = 1;
		cyc(1);
		boost_clk_bad = 0;
		boost_uv = 1;
		cyc(3);
		chk({5'h00, dev_state}, 8'h04);
		boost_enable_bit = 1;
		cyc(2);
		chk({7'h00, boost_en}, 8'h01);
		boost_enable_bit = 0;
		boost_uv_as_reset_setting = 1;
		wait_st(3'h1);
		chk({5'h00, dev_state}, 8'h01);
		chk({6'h00, sync_monitor_enable_bit, pll_track}, 8'h00);
		boost_uv = 0;
		wait_st(3'h2);
		chk({7'h00, reset_output}, 8'h01);
		boost_uv_as_reset_setting = 0;
		$display("test uv handling done");
		power_down_threshold = 4'h1;
		st_fail = 1;
		sd1_uv_rst_en = 1;
		boot();
		wait_st(3'h4);
		chk({7'h00, interrupt_pin_n}, 8'h00);
		wait_st(3'h0);
		chk({4'h0, error_count}, 8'h01);
		st_fail = 0;
		sd1_uv_rst_en = 0;
		power_down_threshold = 4'hF;
		$display("test self-test fail done");
		pll_clk_bad = 1;
		boot();
		chk({7'h00, sd1_en}, 8'h00);
		wait_st(3'h0);
		chk({5'h00, reset_timeout_latch, sd1_en, boost_en}, 8'h04);
		pll_clk_bad = 0;
		$display("test reset timeout done");
		rst = 1;
		cyc(1);
		chk({1'b0, dev_state, error_count}, 8'h00);
		chk({4'h0, interrupt_pin_n, reset_output, sd1_en, reset_timeout_latch}, 8'h08);
		$display("test reset values done");
		close_out();
	end
endmodule

bind switching_clock_fault_reaction clk_fault_checker #(.RST_TO_CYC(RST_TO_CYC)) u_clk_fault_checker (.*);

`default_nettype wire
